// file: src/dis_cfg.svh
// Purpose: timing and encoding constants for decode/issue steering
// Assumes: one core clock
// Notes: definitions only
`ifndef DIS_CFG_SVH
`define DIS_CFG_SVH
`define DIS_NOP_OPCODE 8'h90
`define DIS_SHORT_MAX_LEN 4'h7
`define DIS_MISPRED_MIN 3'h1
`define DIS_MISPRED_MAX 3'h4
`define DIS_PREFIX_FREE 3'h1
`define DIS_LEN_W 4
`endif

// file: src/dis_pkg.sv
// Purpose: types for decode/issue steering
// Assumes: nothing
// Notes: shared enums
package dis_pkg;
  typedef enum logic [2:0] {
    DIS_OP_ALU, DIS_OP_CARRY, DIS_OP_SHIFT_IMM, DIS_OP_FP,
    DIS_OP_COND_BRANCH, DIS_OP_NOP, DIS_OP_LOAD, DIS_OP_STORE
  } dis_op_t;
  typedef enum logic [2:0] {
    DIS_U_NONE, DIS_U_INT_X, DIS_U_INT_Y, DIS_U_FP,
    DIS_U_BRANCH, DIS_U_LOAD, DIS_U_STORE
  } dis_unit_t;
  typedef enum logic [1:0] {
    DIS_DEC_SHORT, DIS_DEC_LONG, DIS_DEC_VECTOR
  } dis_dec_t;
endpackage : dis_pkg

// file: src/dis_steer.sv
// Purpose: decode class selection and issue steering for two slots
// Assumes: fetch supplies pre-classified instructions; inputs synchronous
// Notes: outputs registered; one-cycle latency from slot inputs
// How it works
// - nop 90h uses a short decode slot, never an execution unit.
// - mispredict stalls issue one to four cycles by pipeline state.
// - carry or borrow instructions go only to integer unit X.
// - immediate shifts go only to integer unit X.
// - floating-point ops go to the floating-point unit only.
// - encodings over seven bytes use long or vector decode only.
// - line-straddle stalls only if no full instruction is held.
// - register dependencies never stall or split decode.
// - conditional branches short decode and pair with another short.
// - several prefixes add accumulation delay cycles before decode.
// - running transcendental fp never stalls integer issue.
`timescale 1ns/1ps
`include "dis_cfg.svh"
module dis_steer #(
  parameter int LEN_W = `DIS_LEN_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // slot 0 from fetch
  input wire logic s0_valid_i,
  input wire logic [7:0] s0_opcode_i,
  input wire logic [LEN_W-1:0] s0_len_i,
  input wire dis_pkg::dis_op_t s0_op_i,
  input wire logic s0_vector_i,
  input wire logic [2:0] s0_prefixes_i,
  input wire logic s0_complete_i,
  // slot 1 from fetch
  input wire logic s1_valid_i,
  input wire logic [7:0] s1_opcode_i,
  input wire logic [LEN_W-1:0] s1_len_i,
  input wire dis_pkg::dis_op_t s1_op_i,
  input wire logic s1_vector_i,
  input wire logic s1_complete_i,
  // dependency hint, ignored for decode by design
  input wire logic s1_dep_on_s0_i,
  // pipeline events
  input wire logic mispredict_i,
  input wire logic [2:0] mispred_depth_i,
  input wire logic fp_busy_i,
  // issue outputs
  output logic s0_issue_o,
  output dis_pkg::dis_unit_t s0_unit_o,
  output dis_pkg::dis_dec_t s0_dec_o,
  output logic s1_issue_o,
  output dis_pkg::dis_unit_t s1_unit_o,
  output dis_pkg::dis_dec_t s1_dec_o,
  output logic stall_o,
  output logic take_o
);
  typedef struct packed {
    logic s0_issue;
    dis_pkg::dis_unit_t s0_unit;
    dis_pkg::dis_dec_t s0_dec;
    logic s1_issue;
    dis_pkg::dis_unit_t s1_unit;
    dis_pkg::dis_dec_t s1_dec;
    logic stall;
    logic take;
    logic [2:0] pen_cnt;
    logic [2:0] pre_cnt;
    logic pre_paid;
  } dis_state_t;

  dis_state_t st, next_st;

  function automatic dis_pkg::dis_dec_t dis_class(
    input logic [LEN_W-1:0] len, input logic vec);
    if (vec) begin
      dis_class = dis_pkg::DIS_DEC_VECTOR;
    end else if (len > LEN_W'(`DIS_SHORT_MAX_LEN)) begin
      dis_class = dis_pkg::DIS_DEC_LONG;
    end else begin
      dis_class = dis_pkg::DIS_DEC_SHORT;
    end
  endfunction : dis_class

  function automatic dis_pkg::dis_unit_t dis_route(
    input dis_pkg::dis_op_t op, input logic [7:0] opc, input logic alt);
    case (op)
      dis_pkg::DIS_OP_CARRY: dis_route = dis_pkg::DIS_U_INT_X;
      dis_pkg::DIS_OP_SHIFT_IMM: dis_route = dis_pkg::DIS_U_INT_X;
      dis_pkg::DIS_OP_FP: dis_route = dis_pkg::DIS_U_FP;
      dis_pkg::DIS_OP_COND_BRANCH: dis_route = dis_pkg::DIS_U_BRANCH;
      dis_pkg::DIS_OP_NOP: dis_route = dis_pkg::DIS_U_NONE;
      dis_pkg::DIS_OP_LOAD: dis_route = dis_pkg::DIS_U_LOAD;
      dis_pkg::DIS_OP_STORE: dis_route = dis_pkg::DIS_U_STORE;
      default: dis_route = alt ? dis_pkg::DIS_U_INT_Y : dis_pkg::DIS_U_INT_X;
    endcase
    if (opc == `DIS_NOP_OPCODE && op == dis_pkg::DIS_OP_NOP) begin
      dis_route = dis_pkg::DIS_U_NONE;
    end
  endfunction : dis_route

  logic s0_short, s1_short, pair, pen_load, pre_wait, hold;
  logic [2:0] depth;
  dis_pkg::dis_unit_t u0, u1;

  always_comb begin
    next_st = st;
    s0_short = dis_class(s0_len_i, s0_vector_i) == dis_pkg::DIS_DEC_SHORT;
    s1_short = dis_class(s1_len_i, s1_vector_i) == dis_pkg::DIS_DEC_SHORT;
    u0 = dis_route(s0_op_i, s0_opcode_i, 1'b0);
    // second integer op takes unit Y unless X-only or X is free
    u1 = dis_route(s1_op_i, s1_opcode_i,
                   u0 == dis_pkg::DIS_U_INT_X);
    // clamp penalty into the 1..4 window
    depth = mispred_depth_i;
    if (depth < `DIS_MISPRED_MIN) begin
      depth = `DIS_MISPRED_MIN;
    end else if (depth > `DIS_MISPRED_MAX) begin
      depth = `DIS_MISPRED_MAX;
    end
    pen_load = mispredict_i;
    // extra prefixes beyond the free one each cost a cycle, after one cycle that loads the count
    pre_wait = 1'b0;
    if (st.pre_cnt != 3'h0) begin
      next_st.pre_cnt = st.pre_cnt - 3'h1;
      pre_wait = 1'b1;
      // last wait cycle: the held instruction has paid for its prefixes
      next_st.pre_paid = st.pre_cnt == 3'h1;
    end
    // s1_dep_on_s0_i deliberately not part of any stall term
    // fp_busy_i deliberately not part of any stall term
    // straddle stalls only when nothing complete is held
    hold = pen_load || st.pen_cnt != 3'h0 || pre_wait ||
           (s0_valid_i && !s0_complete_i);
    // without the paid credit a repeated instruction would reload forever
    if (!hold && s0_valid_i && st.pre_cnt == 3'h0 && !st.pre_paid &&
        s0_prefixes_i > `DIS_PREFIX_FREE) begin
      next_st.pre_cnt = s0_prefixes_i - `DIS_PREFIX_FREE;
      hold = 1'b1;
    end
    // two short decodes pair unless both need unit X, branches included
    pair = s0_short && s1_short && s1_valid_i && s1_complete_i &&
           !(u0 == dis_pkg::DIS_U_INT_X && u1 == dis_pkg::DIS_U_INT_X);
    if (pen_load) begin
      next_st.pen_cnt = depth - 3'h1;
    end else if (st.pen_cnt != 3'h0) begin
      next_st.pen_cnt = st.pen_cnt - 3'h1;
    end
    next_st.stall = hold;
    next_st.take = !hold && s0_valid_i;
    next_st.s0_issue = !hold && s0_valid_i &&
                       u0 != dis_pkg::DIS_U_NONE;
    next_st.s0_unit = (!hold && s0_valid_i) ? u0 : dis_pkg::DIS_U_NONE;
    next_st.s0_dec = dis_class(s0_len_i, s0_vector_i);
    next_st.s1_issue = !hold && s0_valid_i && pair &&
                       u1 != dis_pkg::DIS_U_NONE;
    next_st.s1_unit = (!hold && s0_valid_i && pair) ? u1 :
                      dis_pkg::DIS_U_NONE;
    next_st.s1_dec = dis_class(s1_len_i, s1_vector_i);
    // a taken, dropped or flushed instruction leaves no credit behind
    if (next_st.take || !s0_valid_i || mispredict_i) begin
      next_st.pre_paid = 1'b0;
    end
    if (!resetn_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign s0_issue_o = st.s0_issue;
  assign s0_unit_o = st.s0_unit;
  assign s0_dec_o = st.s0_dec;
  assign s1_issue_o = st.s1_issue;
  assign s1_unit_o = st.s1_unit;
  assign s1_dec_o = st.s1_dec;
  assign stall_o = st.stall;
  assign take_o = st.take;

  sequence mispred_seen_s;
    mispredict_i && mispred_depth_i >= `DIS_MISPRED_MAX;
  endsequence
  sequence stalled_four_s;
    stall_o [*4];
  endsequence

  nop_no_unit_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_valid_i && s0_op_i == dis_pkg::DIS_OP_NOP |=>
    s0_unit_o == dis_pkg::DIS_U_NONE && !s0_issue_o)
    else $error("nop sent to a unit");
  mispred_penalty_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    mispred_seen_s |=> stalled_four_s)
    else $error("mispredict penalty wrong");
  carry_x_only_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s1_op_i == dis_pkg::DIS_OP_CARRY |=> s1_unit_o != dis_pkg::DIS_U_INT_Y)
    else $error("carry op on unit y");
  shift_x_only_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_op_i == dis_pkg::DIS_OP_SHIFT_IMM |=>
    s0_unit_o inside {dis_pkg::DIS_U_INT_X, dis_pkg::DIS_U_NONE})
    else $error("shift off unit x");
  fp_unit_only_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_op_i == dis_pkg::DIS_OP_FP |=>
    s0_unit_o inside {dis_pkg::DIS_U_FP, dis_pkg::DIS_U_NONE})
    else $error("fp op to integer pipe");
  long_not_short_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_len_i > LEN_W'(`DIS_SHORT_MAX_LEN) |=>
    s0_dec_o != dis_pkg::DIS_DEC_SHORT)
    else $error("long op short decoded");
  straddle_ok_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_valid_i && s0_complete_i && !mispredict_i && st.pen_cnt == 3'h0 &&
    st.pre_cnt == 3'h0 && s0_prefixes_i <= `DIS_PREFIX_FREE |=> take_o)
    else $error("stall with complete op");
  dep_no_split_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s1_dep_on_s0_i && $past(s1_dep_on_s0_i) |-> !$rose(stall_o) ||
    $past(mispredict_i) || $past(!s0_complete_i) ||
    $past(s0_prefixes_i > `DIS_PREFIX_FREE))
    else $error("dependency stalled decode");
  branch_pair_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    !stall_o && take_o && $past(s1_op_i == dis_pkg::DIS_OP_COND_BRANCH &&
    s1_valid_i && s1_complete_i && !s1_vector_i &&
    s1_len_i <= LEN_W'(`DIS_SHORT_MAX_LEN) &&
    s0_len_i <= LEN_W'(`DIS_SHORT_MAX_LEN) && !s0_vector_i) |-> s1_issue_o)
    else $error("branch not paired");
  prefix_delay_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    s0_valid_i && s0_complete_i && s0_prefixes_i > `DIS_PREFIX_FREE &&
    !stall_o && st.pen_cnt == 3'h0 && !mispredict_i |=> stall_o)
    else $error("prefixes took no delay");
  prefix_once_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    st.pre_paid && s0_valid_i && s0_complete_i && !mispredict_i &&
    st.pen_cnt == 3'h0 |=> take_o)
    else $error("prefixes charged twice");
  fp_no_block_a: assert property (@(posedge clk_i)
    disable iff (!resetn_i)
    $rose(stall_o) |-> $past(mispredict_i) || $past(!s0_complete_i) ||
    $past(s0_prefixes_i > `DIS_PREFIX_FREE) || $past(st.pen_cnt != 3'h0) ||
    $past(st.pre_cnt != 3'h0))
    else $error("stall with no cause");
endmodule : dis_steer

// file: verif/tb_dis_steer.sv
// Purpose: self-checking bench for dis_steer
// Assumes: registered outputs, one cycle after the taking edge
// Notes: driver queues notes, a negedge monitor compares them
`timescale 1ns/1ps
module tb_dis_steer;
  typedef struct packed {
    logic st;
    logic tk;
    logic i0;
    dis_pkg::dis_unit_t u0;
    dis_pkg::dis_dec_t d0;
    logic i1;
    dis_pkg::dis_unit_t u1;
    dis_pkg::dis_dec_t d1;
  } dis_note_t;
  logic clk_i, resetn_i, s0_valid_i, s0_vector_i, s0_complete_i;
  logic s1_valid_i, s1_vector_i, s1_complete_i, s1_dep_on_s0_i;
  logic mispredict_i, fp_busy_i, s0_issue_o, s1_issue_o, stall_o, take_o;
  logic [7:0] s0_opcode_i, s1_opcode_i;
  logic [3:0] s0_len_i, s1_len_i;
  logic [2:0] s0_prefixes_i, mispred_depth_i;
  dis_pkg::dis_op_t s0_op_i, s1_op_i;
  dis_pkg::dis_unit_t s0_unit_o, s1_unit_o;
  dis_pkg::dis_dec_t s0_dec_o, s1_dec_o;
  dis_note_t q[$];
  dis_note_t e, seen;
  int n_errors, cmp_count, cyc;
  dis_steer dis_steer_inst (.clk_i, .resetn_i, .s0_valid_i, .s0_opcode_i,
    .s0_len_i, .s0_op_i, .s0_vector_i, .s0_prefixes_i, .s0_complete_i,
    .s1_valid_i, .s1_opcode_i, .s1_len_i, .s1_op_i, .s1_vector_i,
    .s1_complete_i, .s1_dep_on_s0_i, .mispredict_i, .mispred_depth_i,
    .fp_busy_i, .s0_issue_o, .s0_unit_o, .s0_dec_o, .s1_issue_o,
    .s1_unit_o, .s1_dec_o, .stall_o, .take_o);
  always #20 clk_i = ~clk_i;
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      complete_run();
    end
  end
  // only cycles that show a result consume a note
  always @(negedge clk_i) begin
    if (resetn_i && (take_o === 1'b1 || stall_o === 1'b1)) begin
      seen = {stall_o, take_o, s0_issue_o, s0_unit_o, s0_dec_o, s1_issue_o,
        s1_unit_o, s1_dec_o};
      cmp_count++;
      if (q.size() == 0) begin
        n_errors++;
        $display("Error outputs expected none seen %h", seen);
      end else begin
        e = q.pop_front();
        if (seen !== e) begin
          n_errors++;
          $display("Error outputs expected %h seen %h", e, seen);
        end
      end
    end
  end
  function automatic dis_pkg::dis_unit_t eu(dis_pkg::dis_op_t o);
    case (o)
      dis_pkg::DIS_OP_FP: return dis_pkg::DIS_U_FP;
      dis_pkg::DIS_OP_COND_BRANCH: return dis_pkg::DIS_U_BRANCH;
      dis_pkg::DIS_OP_LOAD: return dis_pkg::DIS_U_LOAD;
      dis_pkg::DIS_OP_STORE: return dis_pkg::DIS_U_STORE;
      dis_pkg::DIS_OP_NOP: return dis_pkg::DIS_U_NONE;
      default: return dis_pkg::DIS_U_INT_X;
    endcase
  endfunction : eu
  task automatic drv(dis_pkg::dis_op_t o0, logic [3:0] l0, logic vc,
      logic [2:0] pf, logic c0, logic v1, dis_pkg::dis_op_t o1, logic c1,
      logic [3:0] l1, int n);
    s0_valid_i <= 1'b1;
    s0_op_i <= o0;
    s0_opcode_i <= (o0 == dis_pkg::DIS_OP_NOP) ? 8'h90 : 8'h01;
    s0_len_i <= l0;
    s0_vector_i <= vc;
    s0_prefixes_i <= pf;
    s0_complete_i <= c0;
    s1_valid_i <= v1;
    s1_op_i <= o1;
    s1_complete_i <= c1;
    s1_len_i <= l1;
    s1_opcode_i <= (o1 == dis_pkg::DIS_OP_NOP) ? 8'h90 : 8'h01;
    // dependency hint and busy fp unit must never change the outcome
    s1_dep_on_s0_i <= 1'($urandom);
    fp_busy_i <= 1'($urandom);
    repeat (n) @(posedge clk_i);
  endtask : drv
  task automatic put(logic st, logic tk, logic i0, dis_pkg::dis_unit_t u0,
      dis_pkg::dis_dec_t d0, logic i1, dis_pkg::dis_unit_t u1,
      dis_pkg::dis_dec_t d1);
    q.push_back({st, tk, i0, u0, d0, i1, u1, d1});
  endtask : put
  task automatic stl(int n);
    repeat (n) put(1, 0, 0, dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
  endtask : stl
  task automatic one(dis_pkg::dis_op_t o0, logic [3:0] l0, logic vc,
      logic v1, dis_pkg::dis_op_t o1, logic c1, logic i1,
      dis_pkg::dis_unit_t u1, dis_pkg::dis_dec_t d0);
    put(0, 1, o0 != dis_pkg::DIS_OP_NOP, eu(o0), d0, i1, u1,
      dis_pkg::DIS_DEC_SHORT);
    drv(o0, l0, vc, 3'h0, 1'b1, v1, o1, c1, 4'h2, 1);
  endtask : one
  task automatic mp(logic [2:0] d, int n);
    s0_valid_i <= 1'b0;
    s1_valid_i <= 1'b0;
    mispredict_i <= 1'b1;
    mispred_depth_i <= d;
    stl(n);
    @(posedge clk_i);
    mispredict_i <= 1'b0;
    repeat (n) @(posedge clk_i);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 0, dis_pkg::DIS_OP_ALU, 1, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
  endtask : mp
  initial begin
    {clk_i, resetn_i, s0_valid_i, s0_vector_i, s0_complete_i, s1_valid_i} = '0;
    {s1_vector_i, s1_complete_i, s1_dep_on_s0_i, mispredict_i} = '0;
    {fp_busy_i, s0_opcode_i, s1_opcode_i, s0_len_i, s1_len_i} = '0;
    {s0_prefixes_i, mispred_depth_i} = '0;
    s0_op_i = dis_pkg::DIS_OP_ALU;
    s1_op_i = dis_pkg::DIS_OP_ALU;
    void'($urandom(32'h24053225));
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      one(dis_pkg::dis_op_t'(k), 4'(1 + $urandom % 7), 0, 0, s1_op_i, 1, 0,
        dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    end
    $display("test single done");
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 1, dis_pkg::DIS_OP_ALU, 1, 1,
      dis_pkg::DIS_U_INT_Y, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_CARRY, 4'h2, 0, 1, dis_pkg::DIS_OP_CARRY, 1, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_SHIFT_IMM, 4'h3, 0, 1, dis_pkg::DIS_OP_SHIFT_IMM, 1,
      0, dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 1, dis_pkg::DIS_OP_COND_BRANCH, 1, 1,
      dis_pkg::DIS_U_BRANCH, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 1, dis_pkg::DIS_OP_FP, 1, 1,
      dis_pkg::DIS_U_FP, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_ALU, 4'h7, 0, 1, dis_pkg::DIS_OP_ALU, 1, 1,
      dis_pkg::DIS_U_INT_Y, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_ALU, 4'h8, 0, 1, dis_pkg::DIS_OP_ALU, 1, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_LONG);
    one(dis_pkg::DIS_OP_ALU, 4'h3, 1, 1, dis_pkg::DIS_OP_ALU, 1, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_VECTOR);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 1, dis_pkg::DIS_OP_ALU, 0, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 1, dis_pkg::DIS_OP_NOP, 1, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    put(0, 1, 1, dis_pkg::DIS_U_INT_X, dis_pkg::DIS_DEC_SHORT, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_LONG);
    drv(dis_pkg::DIS_OP_ALU, 4'h2, 0, 3'h0, 1, 1, dis_pkg::DIS_OP_ALU, 1,
      4'h9, 1);
    $display("test pair done");
    stl(2);
    drv(dis_pkg::DIS_OP_ALU, 4'h2, 0, 3'h0, 0, 0, s1_op_i, 1, 4'h2, 2);
    one(dis_pkg::DIS_OP_ALU, 4'h2, 0, 0, s1_op_i, 1, 0, dis_pkg::DIS_U_NONE,
      dis_pkg::DIS_DEC_SHORT);
    put(0, 1, 1, dis_pkg::DIS_U_INT_X, dis_pkg::DIS_DEC_SHORT, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    drv(dis_pkg::DIS_OP_ALU, 4'h2, 0, 3'h1, 1, 0, s1_op_i, 1, 4'h2, 1);
    stl(3);
    put(0, 1, 1, dis_pkg::DIS_U_INT_X, dis_pkg::DIS_DEC_SHORT, 0,
      dis_pkg::DIS_U_NONE, dis_pkg::DIS_DEC_SHORT);
    drv(dis_pkg::DIS_OP_ALU, 4'h2, 0, 3'h3, 1, 0, s1_op_i, 1, 4'h2, 4);
    $display("test stall done");
    mp(3'h0, 1);
    mp(3'h1, 1);
    mp(3'h3, 3);
    mp(3'h4, 4);
    mp(3'h7, 4);
    $display("test mispredict done");
    s0_valid_i <= 1'b0;
    s1_valid_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    if (q.size() != 0) begin
      n_errors++;
      $display("Error pending expected 0 seen %0d", q.size());
    end
    complete_run();
  end
endmodule : tb_dis_steer
